// ==== msasp_pkg.sv ====
/*
 * Shared constants and types for the multiplexed SAR converter serial port.
 * Assumes a 16-bit unsigned analog model per input, full scale equal to the analog supply.
 */
package msasp_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int RESULT_W = 12;
	localparam int ANALOG_W = 16;
	localparam int CHAN_W   = 3;
	localparam int NUM_CHAN = 8;
	localparam int CTRL_W   = 8;
	localparam int SEL_MSB  = 5;
	localparam int SEL_LSB  = 3;

	// ------------------------------------------------------------------
	// Falling-edge positions within one 16-cycle conversion, and the last control-byte rising edge
	// ------------------------------------------------------------------
	localparam logic [4:0] EDGE_NONE   = 5'h00;
	localparam logic [4:0] EDGE_FIRST  = 5'h01;
	localparam logic [4:0] EDGE_SECOND = 5'h02;
	localparam logic [4:0] EDGE_HOLD   = 5'h04;
	localparam logic [4:0] EDGE_MSB    = 5'h05;
	localparam logic [4:0] EDGE_LAST   = 5'h10;
	localparam logic [3:0] RISE_CTRL_LAST = 4'h7;

	// ------------------------------------------------------------------
	// Transfer function: one code step is 16 analog units (65536 / 4096)
	// and the first transition sits half a step up (65536 / 8192 = 8).
	// ------------------------------------------------------------------
	localparam logic [ANALOG_W:0]   HALF_STEP  = 17'h00008;
	localparam logic [3:0]          STEP_PAD   = 4'h0;
	localparam logic [RESULT_W-1:0] MSB_MASK   = 12'h800;
	localparam logic [RESULT_W-1:0] CODE_RESET = 12'h000;
	localparam logic [CHAN_W-1:0]   CHAN_RESET = 3'h0;
	localparam logic [CTRL_W-1:0]   CTRL_RESET = 8'h00;
	localparam logic [3:0]          RISE_RESET = 4'h0;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [NUM_CHAN-1:0][ANALOG_W-1:0] msasp_analog_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_TRACK,
		PH_CONVERT,
		PH_GAP
	} msasp_phase_e;

	typedef struct packed {
		logic                powered;
		logic                tracking;
		logic                result_valid;
		logic [CHAN_W-1:0]   channel;
		logic [RESULT_W-1:0] result;
	} msasp_status_s;

	localparam msasp_status_s STATUS_RESET = '0;

endpackage

// ==== msasp_sync.sv ====
/*
 * Two-stage synchroniser for levels and quasi-static words entering clk_in.
 * Assumes multi-bit data only changes while the receiver does not use it.
 */
`timescale 1ns/10ps
module msasp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end

endmodule // msasp_sync

// ==== msasp_port.sv ====
/*
 * Serial control and sequencing of an eight-input 12-bit SAR converter.
 * Assumes the host frames with chip select, clocks with sclk_in and samples serial_out.
 * The analog inputs are modelled as 16-bit words on the system clock.
 */
// What this block does
// - Track three cycles, then convert twelve cycles.
// - Straight binary code, half-step first transition.
// - Powered while chip select low, else down.
// - Power down from edge 16 to next edge 1.
// - Sixteen cycles per conversion, back to back.
// - Serial output driven only while chip select low.
// - Clock ignored while chip select high.
// - Four zeros, then twelve result bits MSB first.
// - Retrack after rising N*16, hold at N*16+4.
// - Select falls with clock high: track next fall.
// - Select falls with clock low: counts as edge one.
// - Select and clock fall together: enter tracking.
// - No ordering between select and clock rises.
// - Control byte captured on first eight rising edges.
// - Bits five to three select channel, others ignored.
// - Selection applies to the next conversion.
// - First conversion after power-up uses input zero.
`timescale 1ns/10ps
module msasp_port (
	input  wire logic                    clk_sys_in,
	input  wire logic                    reset_in,
	input  wire logic                    sclk_in,
	input  wire logic                    cs_n_in,
	input  wire logic                    serial_in,
	output logic                         serial_out,
	output logic                         serial_out_oe_n,
	input  wire msasp_pkg::msasp_analog_t analog_in,
	output msasp_pkg::msasp_status_s     status_out
);
	import msasp_pkg::*;

	// ------------------------------------------------------------------
	// Link-side reset
	// ------------------------------------------------------------------
	// Chip select high holds the link-side counters and phase in reset, so any clock
	// activity outside a frame is ignored and the frame order of the rising
	// edges of select and clock does not matter.
	logic link_rst;
	assign link_rst = reset_in | cs_n_in;

	// ------------------------------------------------------------------
	// Output enable
	// ------------------------------------------------------------------
	// Chip select is the output enable; it acts without waiting for a clock
	// edge because a frame that opens with the clock low has none to wait for.
	// That is also why this one output is not taken from a register.
	assign serial_out_oe_n = cs_n_in;

	// ------------------------------------------------------------------
	// Frame start: level of the clock when select fell
	// ------------------------------------------------------------------
	logic start_low;

	always_ff @(negedge cs_n_in or posedge reset_in) begin
		if (reset_in) begin
			start_low <= 1'b0;
		end else begin
			start_low <= ~sclk_in;
		end
	end

	// ------------------------------------------------------------------
	// Falling-edge sequencing
	// ------------------------------------------------------------------
	logic [4:0]          edge_num;
	msasp_phase_e        phase;
	logic [RESULT_W-1:0] sar_code;
	logic [CHAN_W-1:0]   conv_channel;
	logic                link_track;
	logic                link_gap;
	logic                link_idle;

	logic [4:0]          next_edge_num;
	msasp_phase_e        next_phase;
	logic                first_edge;
	logic                wrap_edge;
	logic                in_result;
	logic                at_hold;
	logic                at_last;
	logic                load_chan;
	logic                next_track;
	logic                next_gap;
	logic [RESULT_W-1:0] bit_mask;
	logic [RESULT_W-1:0] trial_code;
	logic                sar_decide;
	logic [RESULT_W-1:0] next_sar_code;
	logic [ANALOG_W:0]   held_word;

	function automatic logic [RESULT_W-1:0] sar_mask(input logic [4:0] edge_pos);
		logic [4:0] shift;
		shift = edge_pos - EDGE_MSB;
		return MSB_MASK >> shift;
	endfunction

	// A frame opened with the clock low has already used edge one at the
	// select fall, so its first real falling edge is edge two.
	assign first_edge    = (edge_num == EDGE_NONE);
	assign wrap_edge     = (edge_num == EDGE_LAST);
	assign next_edge_num = first_edge ? (start_low ? EDGE_SECOND : EDGE_FIRST)
	                     : wrap_edge ? EDGE_FIRST
	                     : edge_num + 5'h01;
	assign at_hold       = (next_edge_num == EDGE_HOLD);
	assign at_last       = (next_edge_num == EDGE_LAST);
	assign in_result     = (next_edge_num >= EDGE_MSB);

	always_comb begin
		next_phase = phase;
		unique case (phase)
			PH_IDLE: next_phase = PH_TRACK;
			PH_TRACK: begin
				if (at_hold) begin
					next_phase = PH_CONVERT;
				end
			end
			PH_CONVERT: begin
				if (at_last) begin
					next_phase = PH_GAP;
				end
			end
			PH_GAP: next_phase = PH_TRACK;
		endcase
	end

	assign next_track = (next_phase == PH_TRACK);
	assign next_gap   = (next_phase == PH_GAP);
	assign load_chan  = next_track && (phase != PH_TRACK);

	// Successive approximation: each decision is the bit shifted out on the
	// same falling edge, so no result register is needed before the output.
	assign bit_mask      = sar_mask(next_edge_num);
	assign trial_code    = sar_code | bit_mask;
	assign sar_decide    = in_result && (held_word >= {1'b0, trial_code, STEP_PAD});
	assign next_sar_code = sar_decide ? trial_code : sar_code;

	always_ff @(negedge sclk_in or posedge link_rst) begin
		if (link_rst) begin
			edge_num <= EDGE_NONE;
			phase    <= PH_IDLE;
		end else begin
			edge_num <= next_edge_num;
			phase    <= next_phase;
		end
	end

	always_ff @(negedge sclk_in or posedge link_rst) begin
		if (link_rst) begin
			serial_out <= 1'b0;
			sar_code   <= CODE_RESET;
		end else begin
			serial_out <= sar_decide;
			sar_code   <= at_hold ? CODE_RESET : next_sar_code;
		end
	end

	always_ff @(negedge sclk_in or posedge link_rst) begin
		if (link_rst) begin
			link_track <= 1'b0;
			link_gap   <= 1'b0;
			link_idle  <= 1'b1;
		end else begin
			link_track <= next_track;
			link_gap   <= next_gap;
			link_idle  <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Rising-edge control byte capture
	// ------------------------------------------------------------------
	logic [3:0]        rise_num;
	logic [CTRL_W-1:0] ctl_shift;
	logic [CTRL_W-1:0] ctrl_byte;
	logic [CHAN_W-1:0] pending_channel;

	assign ctrl_byte = {ctl_shift[CTRL_W-2:0], serial_in};

	always_ff @(posedge sclk_in or posedge link_rst) begin
		if (link_rst) begin
			rise_num  <= RISE_RESET;
			ctl_shift <= CTRL_RESET;
		end else begin
			rise_num  <= rise_num + 4'h1;
			ctl_shift <= ctrl_byte;
		end
	end

	// Survives chip select so a selection made in one frame applies to the
	// first conversion of the next; only the system reset restores input zero.
	always_ff @(posedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			pending_channel <= CHAN_RESET;
		end else if (rise_num == RISE_CTRL_LAST) begin
			pending_channel <= ctrl_byte[SEL_MSB:SEL_LSB];
		end
	end

	// ------------------------------------------------------------------
	// Link-side events that outlive the frame
	// ------------------------------------------------------------------
	logic                hold_tgl;
	logic                done_tgl;
	logic [RESULT_W-1:0] result_word;
	logic [CHAN_W-1:0]   result_chan;
	logic                link_load;
	logic                link_hold;
	logic                link_last;

	// Chip select gates these events as well, because their registers keep
	// their value across frames and only the system reset clears them.
	assign link_load = load_chan & ~link_rst;
	assign link_hold = at_hold & ~link_rst;
	assign link_last = at_last & ~link_rst;

	always_ff @(negedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			conv_channel <= CHAN_RESET;
		end else if (link_load) begin
			conv_channel <= pending_channel;
		end
	end

	always_ff @(negedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			hold_tgl <= 1'b0;
		end else if (link_hold) begin
			hold_tgl <= ~hold_tgl;
		end
	end

	// The result and its channel settle with the toggle and then stand for a
	// whole conversion, so the system side reads them without a synchroniser.
	always_ff @(negedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			done_tgl    <= 1'b0;
			result_word <= CODE_RESET;
			result_chan <= CHAN_RESET;
		end else if (link_last) begin
			done_tgl    <= ~done_tgl;
			result_word <= next_sar_code;
			result_chan <= conv_channel;
		end
	end

	// ------------------------------------------------------------------
	// Crossing into the system clock
	// ------------------------------------------------------------------
	// The channel word is stable for several link periods around the hold
	// toggle, so a plain two-stage capture is safe for it.
	localparam int XW = 7 + CHAN_W;

	logic [XW-1:0]    x_link;
	logic [XW-1:0]    x_sys;
	msasp_analog_t    analog_sync;
	logic             cs_n_s;
	logic             track_s;
	logic             gap_s;
	logic             idle_s;
	logic             start_low_s;
	logic             hold_s;
	logic             done_s;
	logic [CHAN_W-1:0] chan_s;

	assign x_link = {cs_n_in, link_track, link_gap, link_idle, start_low, hold_tgl, done_tgl, conv_channel};
	assign {cs_n_s, track_s, gap_s, idle_s, start_low_s, hold_s, done_s, chan_s} = x_sys;

	msasp_sync #(
		.WIDTH (XW)
	) u_link_sync (
		.clk_in   (clk_sys_in),
		.reset_in (reset_in),
		.d_in     (x_link),
		.q_out    (x_sys)
	);

	msasp_sync #(
		.WIDTH (NUM_CHAN * ANALOG_W)
	) u_analog_sync (
		.clk_in   (clk_sys_in),
		.reset_in (reset_in),
		.d_in     (analog_in),
		.q_out    (analog_sync)
	);

	// ------------------------------------------------------------------
	// System-side track and hold, power and status
	// ------------------------------------------------------------------
	logic          hold_seen;
	logic          done_seen;
	logic          hold_evt;
	logic          done_evt;
	logic          next_powered;
	logic          next_tracking;
	logic [ANALOG_W:0] next_held;

	assign hold_evt      = hold_s ^ hold_seen;
	assign done_evt      = done_s ^ done_seen;
	assign next_powered  = ~cs_n_s & ~gap_s;
	assign next_tracking = ~cs_n_s & (track_s | (idle_s & start_low_s));
	assign next_held     = {1'b0, analog_sync[chan_s]} + HALF_STEP;

	// The hold toggle needs up to three system clocks to reach the held word, so the link
	// clock period must stay above about three system clocks for the word
	// to settle before the fifth falling edge reads its first bit.
	// The held word follows the selected input until the hold event, then
	// stays frozen while the link side reads it bit by bit.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			held_word <= HALF_STEP;
			hold_seen <= 1'b0;
		end else begin
			hold_seen <= hold_s;
			if (next_tracking || hold_evt) begin
				held_word <= next_held;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			status_out <= STATUS_RESET;
			done_seen  <= 1'b0;
		end else begin
			done_seen               <= done_s;
			status_out.powered      <= next_powered;
			status_out.tracking     <= next_tracking;
			status_out.result_valid <= done_evt;
			if (done_evt) begin
				status_out.result  <= result_word;
				status_out.channel <= result_chan;
			end
		end
	end

endmodule // msasp_port

// ==== msasp_port_props.sv ====
/* Concurrent checks on the msasp_port ports, bound into every instance.
 * Assumes analog_in holds still while a completed result is reported. */
`timescale 1ns/10ps
module msasp_port_props (
	input  wire logic                     clk_sys_in,
	input  wire logic                     reset_in,
	input  wire logic                     sclk_in,
	input  wire logic                     cs_n_in,
	input  wire logic                     serial_in,
	input  wire logic                     serial_out,
	input  wire logic                     serial_out_oe_n,
	input  wire msasp_pkg::msasp_analog_t analog_in,
	input  wire msasp_pkg::msasp_status_s status_out
);
	import msasp_pkg::*;
	logic [ANALOG_W:0]   sum;
	logic [RESULT_W-1:0] exp_code;

	// The top code saturates, so an input at full scale must still read 12'hFFF.
	assign sum      = {1'b0, analog_in[status_out.channel]} + HALF_STEP;
	assign exp_code = sum[ANALOG_W] ? 12'hFFF : sum[15:4];

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	oe_tracks_cs_a: assert property (serial_out_oe_n == cs_n_in) else $error("oe differs from cs");
	dout_idle_a: assert property (cs_n_in && $past(cs_n_in) |-> !serial_out) else $error("data while idle");
	idle_down_a: assert property (cs_n_in [*4] |-> !status_out.powered && !status_out.tracking)
		else $error("active while deselected");
	frame_power_a: assert property ($fell(cs_n_in) |-> ##[1:8] status_out.powered) else $error("no power up");
	valid_pulse_a: assert property (status_out.result_valid |=> !status_out.result_valid) else $error("long valid");
	result_hold_a: assert property (!status_out.result_valid |-> $stable(status_out.result))
		else $error("result moved");
	code_map_a: assert property (status_out.result_valid |-> status_out.result == exp_code)
		else $error("wrong code");
	quiet_valid_a: assert property (cs_n_in [*6] |-> !status_out.result_valid) else $error("valid while idle");
	gap_power_a: assert property (status_out.result_valid |-> !status_out.powered)
		else $error("powered in gap");
	hold_done_a: assert property (status_out.result_valid |-> !status_out.tracking)
		else $error("tracking at result");

	cover property (status_out.result_valid && status_out.channel == 3'h7);
	cover property ($fell(cs_n_in) && !sclk_in);
	cover property ($fell(status_out.powered) && !cs_n_in);
endmodule // msasp_port_props

bind msasp_port msasp_port_props u_props (.clk_sys_in, .reset_in, .sclk_in, .cs_n_in, .serial_in,
	.serial_out, .serial_out_oe_n, .analog_in, .status_out);

// ==== msasp_host.sv ====
/* Host serial controller model that frames conversions for msasp_port.
 * Assumes the device changes its data line only after clock falls. */
`timescale 1ns/10ps
module msasp_host (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      data_out,
	input  wire logic data_in
);
	initial begin
		sclk_out = 1'b1;
		data_out = 1'b0;
		// Deselected after time zero so the link reset sees a real edge.
		#1;
		cs_n_out = 1'b1;
	end

	// A low start parks the clock first, so the select fall itself is the first fall.
	task automatic open(input logic low_start);
		if (low_start) begin
			sclk_out = 1'b0;
			#80;
		end
		cs_n_out = 1'b0;
		if (!low_start) begin
			#40;
		end
	endtask

	task automatic convert(input logic [7:0] ctrl, output logic [15:0] word);
		word = '0;
		for (int i = 0; i < 16; i++) begin
			sclk_out = 1'b0;
			data_out = (i < 8) ? ctrl[7 - i] : ~data_out;
			#80;
			sclk_out = 1'b1;
			word = {word[14:0], data_in};
			#80;
		end
	endtask

	// Released data is inverted so a stale level is never mistaken for a held one.
	task automatic close();
		cs_n_out = 1'b1;
		data_out = ~data_out;
	endtask
endmodule // msasp_host

// ==== tb_msasp_port.sv ====
/* Self-checking bench for msasp_port with a host model on the serial link.
 * Assumes the link clock runs only inside frames at a 160 ns period. */
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
	$display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module tb_msasp_port;
	import msasp_pkg::*;
	logic          clk_sys_in = 1'b0;
	logic          reset_in   = 1'b0;
	msasp_analog_t analog_in  = '0;
	wire logic     sclk, cs_n, sdin, sdout;
	logic          serial_out, serial_out_oe_n;
	msasp_status_s status_out;
	logic [14:0]   exp_q[$];
	logic [14:0]   exp_e;
	logic [15:0]   rnd = 16'h001F;
	int            num_errors = 0;
	int            comparisons = 0;
	int            pend = 0;

	always #12.5 clk_sys_in = ~clk_sys_in;
	assign sdout = serial_out_oe_n ? 1'bz : serial_out;

	msasp_port u_dut (.clk_sys_in, .reset_in, .sclk_in(sclk), .cs_n_in(cs_n), .serial_in(sdin),
		.serial_out, .serial_out_oe_n, .analog_in, .status_out);
	msasp_host u_host (.sclk_out(sclk), .cs_n_out(cs_n), .data_out(sdin), .data_in(sdout));

	function automatic int code_of(input int v);
		return ((v + 8) / 16 > 4095) ? 4095 : (v + 8) / 16;
	endfunction

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic set_analog();
		@(posedge clk_sys_in);
		#2;
		for (int k = 0; k < NUM_CHAN; k++) begin
			rnd = lfsr(rnd);
			analog_in[k] = rnd;
		end
		analog_in[1] = 16'h0007;
		analog_in[2] = 16'h0008;
		analog_in[7] = 16'hFFFF;
		repeat (8) @(posedge clk_sys_in);
	endtask

	task automatic run_frame(input logic low, input int n, input int first);
		logic [7:0]  ctrl;
		logic [15:0] word;
		int          ch;
		u_host.open(low);
		#1 `CHECK("oe_n", 1'b0, serial_out_oe_n)
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			ch = (first + i) % 8;
			ctrl = {rnd[7:6], ch[2:0], rnd[2:0]};
			exp_q.push_back({pend[2:0], 12'(code_of(int'(analog_in[pend])))});
			u_host.convert(ctrl, word);
			`CHECK("word", {4'h0, 12'(code_of(int'(analog_in[pend])))}, word)
			pend = ch;
		end
		u_host.close();
		#1 `CHECK("oe_n", 1'b1, serial_out_oe_n)
		#400;
	endtask

	task automatic test_done();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		if (status_out.result_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("unexpected result_valid: expected 0 seen 1");
			end else begin
				exp_e = exp_q.pop_front();
				`CHECK("channel", exp_e[14:12], status_out.channel)
				`CHECK("result", exp_e[11:0], status_out.result)
			end
		end
	end

	initial begin
		#200000;
		num_errors++;
		test_done();
	end

	initial begin
		// Raised after time zero so the reset edge reaches every register.
		#1;
		reset_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#2;
		reset_in = 1'b0;
		set_analog();
		run_frame(1'b0, 8, 1);
		$display("test 1 done");
		run_frame(1'b1, 2, 3);
		$display("test 2 done");
		for (int f = 0; f < 4; f++) begin
			set_analog();
			run_frame(1'b0, 1, f * 3);
		end
		$display("test 3 done");
		@(posedge clk_sys_in);
		#2;
		reset_in = 1'b1;
		repeat (8) @(posedge clk_sys_in);
		#2;
		reset_in = 1'b0;
		pend = 0;
		repeat (4) @(posedge clk_sys_in);
		#2;
		`CHECK("status", STATUS_RESET, status_out)
		`CHECK("serial_out", 1'b0, serial_out)
		run_frame(1'b0, 2, 6);
		$display("test 4 done");
		`CHECK("pending", 0, exp_q.size())
		test_done();
	end
endmodule // tb_msasp_port
